//--- design/sap_pkg.sv
package sap_pkg;

  // host-side pins, sampled as one bundle
  typedef struct packed {
    logic sclk;
    logic cs_bar;
    logic frame_sync;
    logic serial_in;
    logic sample_start_bar;
  } sap_pins_t;

  // conversion sequencer states
  typedef enum logic [1:0] {
    SAP_IDLE    = 2'b00,
    SAP_SAMPLE  = 2'b01,
    SAP_CONVERT = 2'b10
  } sap_state_t;

  // frame layout
  localparam logic [4:0] SAP_FRAME_EDGES = 5'h10;
  localparam logic [4:0] SAP_CMD_EDGE = 5'h04;
  localparam logic [3:0] SAP_TAIL_ZEROS = 4'h0;

  // commands: 0..7 external channels, self tests, config write
  localparam logic [3:0] SAP_CMD_LAST_CHAN = 4'h7;
  localparam logic [3:0] SAP_CMD_TEST_FIRST = 4'hB;
  localparam logic [3:0] SAP_CMD_TEST_LAST = 4'hD;
  localparam logic [3:0] SAP_CMD_CFG_WRITE = 4'hA;

  // conversion mode in which the status pin acts as end of conversion
  localparam logic [1:0] SAP_MODE_EOC = 2'h0;

  // sampling periods in serial clock periods
  localparam logic [5:0] SAP_SHORT_SCLKS = 6'h0C;
  localparam logic [5:0] SAP_LONG_SCLKS = 6'h18;

  // conversion time at the reference serial clock rate
  localparam int SAP_CONV_TIME_NS = 1600;
  localparam int SAP_SCLK_REF_KHZ = 20000;
  localparam logic [5:0] SAP_CONV_SCLKS = 6'((SAP_CONV_TIME_NS * SAP_SCLK_REF_KHZ) / 1000000);

  // reset values
  localparam logic [11:0] SAP_RESULT_RST = 12'h000;
  localparam logic [3:0] SAP_MUX_RST = 4'h0;
  // idle pin levels; synchroniser and edge register both reset to these
  localparam sap_pins_t SAP_PINS_IDLE = '{sclk: 1'b0, cs_bar: 1'b1, frame_sync: 1'b1, serial_in: 1'b0,
    sample_start_bar: 1'b1};

  // conversion-type command: external channel or self-test voltage
  function automatic logic sap_is_conv(input logic [3:0] cmd);
    return (cmd <= SAP_CMD_LAST_CHAN) || ((cmd >= SAP_CMD_TEST_FIRST) && (cmd <= SAP_CMD_TEST_LAST));
  endfunction

endpackage

//--- design/sap_port.sv
`timescale 1ns/1ps
// Summary of operation
// - chip select fall: clear count, enable output, input only if sync high
// - input stops at 16 edges or chip-select rise
// - chip select high: output to high impedance
// - sample start fall begins sampling
// - sample start rise holds and converts
// - sample start works without chip select
// - eoc low from hold until data ready
// - eoc behaviour only in mode 00
// - interrupt falls when result is ready
// - interrupt cleared by select fall, sync rise
// - interrupt fall releases serial output
// - normal sampling starts after fourth edge
// - sampling lasts 12 or 24 clocks
// - conversion clocked by serial clock, 32 periods
// - command selects channel or test voltage
// - frame sync fall restarts count, enables input
// - msb first, command nibble, config data
// - capture edge rising, falling with sync
// - shift previous result, four zeros, release
module sap_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host pins
  input wire sap_pkg::sap_pins_t pins,
  output logic serial_out,
  output logic serial_out_oe,
  output logic status_out,
  // configuration
  input wire logic status_is_int,
  input wire logic [1:0] conv_mode,
  input wire logic long_sample,
  // analog core
  input wire logic [11:0] adc_result,
  output logic sample_track,
  output logic [3:0] mux_select,
  output logic [11:0] cfg_data,
  output logic cfg_strobe
);
  import sap_pkg::*;

  sap_pins_t s;
  sap_pins_t d_reg;

  // every pin, sample start included, crosses through two flops
  sap_sync #(.WIDTH($bits(sap_pins_t)), .RST_VAL(SAP_PINS_IDLE)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d_in(pins),
    .q_out(s)
  );

  // previous synchronised value for edge finding
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      d_reg <= SAP_PINS_IDLE;
    end else begin
      d_reg <= s;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, fs_fall, fs_rise, ss_fall, ss_rise;
  assign sclk_rise = s.sclk & ~d_reg.sclk;
  assign sclk_fall = ~s.sclk & d_reg.sclk;
  assign cs_fall = ~s.cs_bar & d_reg.cs_bar;
  assign cs_rise = s.cs_bar & ~d_reg.cs_bar;
  assign fs_fall = ~s.frame_sync & d_reg.frame_sync;
  assign fs_rise = s.frame_sync & ~d_reg.frame_sync;
  assign ss_fall = ~s.sample_start_bar & d_reg.sample_start_bar;
  assign ss_rise = s.sample_start_bar & ~d_reg.sample_start_bar;

  // frame state
  logic in_en_reg, in_en_next;
  logic fs_mode_reg, fs_mode_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] in_sh_reg, in_sh_next;
  logic [15:0] out_sh_reg, out_sh_next;
  logic oe_reg, oe_next;
  logic so_reg, so_next;
  logic [3:0] mux_reg, mux_next;
  logic [11:0] cfg_reg, cfg_next;
  logic strobe_reg, strobe_next;
  // conversion state
  sap_state_t state_reg, state_next;
  logic [5:0] ccnt_reg, ccnt_next;
  logic ext_reg, ext_next;
  logic track_reg, track_next;
  logic [11:0] result_reg, result_next;
  logic status_reg, status_next;

  logic shift_edge, cmd_edge, conv_done, norm_start;
  logic [3:0] cmd4;
  logic [4:0] cnt_inc;
  logic [5:0] ccnt_inc, sample_len;

  assign shift_edge = fs_mode_reg ? sclk_fall : sclk_rise;
  assign cnt_inc = cnt_reg + 5'h01;
  assign cmd4 = {in_sh_reg[2:0], s.serial_in};
  // a frame restart on the same cycle wins, so no channel latch or sampling from a dropped count
  assign cmd_edge = in_en_reg && shift_edge && !s.cs_bar && !cs_fall && !fs_fall && (cnt_inc == SAP_CMD_EDGE);
  assign norm_start = cmd_edge && sap_is_conv(cmd4);
  assign ccnt_inc = ccnt_reg + 6'h01;
  assign sample_len = long_sample ? SAP_LONG_SCLKS : SAP_SHORT_SCLKS;

  // serial frame: counter, shift registers, output enable
  always_comb begin
    in_en_next = in_en_reg;
    fs_mode_next = fs_mode_reg;
    cnt_next = cnt_reg;
    in_sh_next = in_sh_reg;
    out_sh_next = out_sh_reg;
    oe_next = oe_reg;
    so_next = so_reg;
    mux_next = mux_reg;
    cfg_next = cfg_reg;
    strobe_next = 1'b0;
    if (cs_fall) begin
      cnt_next = '0;
      fs_mode_next = ~s.frame_sync;
      in_en_next = s.frame_sync;
      oe_next = 1'b1;
      out_sh_next = {result_reg, SAP_TAIL_ZEROS};
      so_next = result_reg[11];
    end else if (cs_rise) begin
      in_en_next = 1'b0;
      oe_next = 1'b0;
    end else if (fs_fall && !s.cs_bar) begin
      cnt_next = '0;
      in_en_next = 1'b1;
      fs_mode_next = 1'b1;
      out_sh_next = {result_reg, SAP_TAIL_ZEROS};
      so_next = result_reg[11];
    end else if (in_en_reg && shift_edge) begin
      in_sh_next = {in_sh_reg[14:0], s.serial_in};
      out_sh_next = {out_sh_reg[14:0], 1'b0};
      so_next = out_sh_reg[14];
      cnt_next = cnt_inc;
      if (cmd_edge && sap_is_conv(cmd4)) begin
        mux_next = cmd4;
      end
      if (cnt_inc == SAP_FRAME_EDGES) begin
        in_en_next = 1'b0;
        oe_next = 1'b0;
        if (in_sh_reg[14:11] == SAP_CMD_CFG_WRITE) begin
          cfg_next = {in_sh_reg[10:0], s.serial_in};
          strobe_next = 1'b1;
        end
      end
    end
    // interrupt edge drops the driver even mid-frame
    if (conv_done && status_is_int) begin
      oe_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_en_reg <= 1'b0;
      fs_mode_reg <= 1'b0;
      cnt_reg <= '0;
      in_sh_reg <= '0;
      out_sh_reg <= '0;
      oe_reg <= 1'b0;
      so_reg <= 1'b0;
      mux_reg <= SAP_MUX_RST;
      cfg_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      in_en_reg <= in_en_next;
      fs_mode_reg <= fs_mode_next;
      cnt_reg <= cnt_next;
      in_sh_reg <= in_sh_next;
      out_sh_reg <= out_sh_next;
      oe_reg <= oe_next;
      so_reg <= so_next;
      mux_reg <= mux_next;
      cfg_reg <= cfg_next;
      strobe_reg <= strobe_next;
    end
  end

  // sample/convert sequencer; timed by serial clock periods, so it stalls if the host stops the clock
  always_comb begin
    state_next = state_reg;
    ccnt_next = ccnt_reg;
    ext_next = ext_reg;
    track_next = track_reg;
    result_next = result_reg;
    conv_done = 1'b0;
    unique case (state_reg)
      SAP_IDLE: begin
        if (ss_fall) begin
          state_next = SAP_SAMPLE;
          ext_next = 1'b1;
          track_next = 1'b1;
        end else if (norm_start) begin
          state_next = SAP_SAMPLE;
          ext_next = 1'b0;
          ccnt_next = '0;
          track_next = 1'b1;
        end
      end
      SAP_SAMPLE: begin
        if (ext_reg) begin
          if (ss_rise) begin
            state_next = SAP_CONVERT;
            ccnt_next = '0;
            track_next = 1'b0;
          end
        end else if (sclk_rise) begin
          ccnt_next = ccnt_inc;
          if (ccnt_inc == sample_len) begin
            state_next = SAP_CONVERT;
            ccnt_next = '0;
            track_next = 1'b0;
          end
        end
      end
      SAP_CONVERT: begin
        if (sclk_rise) begin
          ccnt_next = ccnt_inc;
          if (ccnt_inc == SAP_CONV_SCLKS) begin
            state_next = SAP_IDLE;
            result_next = adc_result;
            conv_done = 1'b1;
          end
        end
      end
      default: begin
        state_next = SAP_IDLE;
        track_next = 1'b0;
      end
    endcase
    // status pin: eoc level or sticky interrupt, new data beats a clear
    if (!status_is_int) begin
      status_next = !((state_next == SAP_CONVERT) && (conv_mode == SAP_MODE_EOC));
    end else if (conv_done) begin
      status_next = 1'b0;
    end else if (cs_fall || fs_rise) begin
      status_next = 1'b1;
    end else begin
      status_next = status_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SAP_IDLE;
      ccnt_reg <= '0;
      ext_reg <= 1'b0;
      track_reg <= 1'b0;
      result_reg <= SAP_RESULT_RST;
      status_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ccnt_reg <= ccnt_next;
      ext_reg <= ext_next;
      track_reg <= track_next;
      result_reg <= result_next;
      status_reg <= status_next;
    end
  end

  // outputs straight from flops
  assign serial_out = so_reg;
  assign serial_out_oe = oe_reg;
  assign status_out = status_reg;
  assign sample_track = track_reg;
  assign mux_select = mux_reg;
  assign cfg_data = cfg_reg;
  assign cfg_strobe = strobe_reg;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_cs_fall_start: assert property (cs_fall && !(conv_done && status_is_int) |=> serial_out_oe && cnt_reg == 5'h00)
    else $error("chip select fall did not start frame");
  a_input_stop16: assert property (cnt_reg == SAP_FRAME_EDGES |-> !in_en_reg)
    else $error("input still enabled after 16 edges");
  a_cs_rise_hiz: assert property (cs_rise && !conv_done |=> !serial_out_oe ##1 !serial_out_oe)
    else $error("output driven after chip select rise");
  a_ss_fall_track: assert property (ss_fall && state_reg == SAP_IDLE |=> sample_track && ext_reg)
    else $error("sample start fall did not begin sampling");
  a_ss_rise_hold: assert property (state_reg == SAP_SAMPLE && ext_reg && ss_rise |=>
    !sample_track && state_reg == SAP_CONVERT)
    else $error("sample start rise did not hold");
  a_eoc_low: assert property (!$past(status_is_int) && $past(conv_mode) == SAP_MODE_EOC &&
    state_reg == SAP_CONVERT |-> !status_out)
    else $error("eoc not low during conversion");
  a_eoc_other_mode: assert property (!$past(status_is_int) && $past(conv_mode) != SAP_MODE_EOC |-> status_out)
    else $error("eoc active outside mode 00");
  a_int_fall: assert property (status_is_int && conv_done |=> !status_out && !serial_out_oe)
    else $error("interrupt did not fall or release output");
  a_int_clear: assert property (status_is_int && !conv_done && cs_fall |=> status_out)
    else $error("interrupt not cleared by chip select");
  a_norm_start: assert property (state_reg == SAP_IDLE && norm_start && !ss_fall |=>
    state_reg == SAP_SAMPLE && !ext_reg ##1 sample_track)
    else $error("normal sampling did not start");
  a_sample_len: assert property (state_reg == SAP_SAMPLE && !ext_reg && sclk_rise &&
    ccnt_inc == sample_len |=> state_reg == SAP_CONVERT)
    else $error("sampling period length wrong");
  a_conv_len: assert property (state_reg == SAP_CONVERT && sclk_rise && ccnt_reg == SAP_CONV_SCLKS - 6'h01 |=>
    state_reg == SAP_IDLE && result_reg == $past(adc_result))
    else $error("conversion length wrong");
  a_mux_latch: assert property (norm_start |=> mux_select == $past(cmd4))
    else $error("channel not latched from command");
  a_fs_restart: assert property (fs_fall && !s.cs_bar && !cs_fall && !cs_rise |=> in_en_reg && cnt_reg == 5'h00)
    else $error("frame sync fall did not restart");
  a_load_prev: assert property (cs_fall |=> serial_out == $past(result_reg[11]))
    else $error("first bit is not previous result msb");

  c_spi_frame: cover property (cs_fall ##[1:1000] cnt_reg == SAP_FRAME_EDGES);
  c_ext_sample: cover property (ss_fall ##[1:1000] (state_reg == SAP_CONVERT && ext_reg));
  c_norm_done: cover property (norm_start ##[1:1000] conv_done);
  c_cfg_write: cover property (cfg_strobe);
endmodule // sap_port

//--- design/sap_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the core clock domain
module sap_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage only feeds the second; reset to idle levels so no false edge follows reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule // sap_sync

//--- testbench/sap_host_model.sv
`timescale 1ns/1ps
// host serial port; its clock stands still outside frames and conversion runs
module sap_host_model (
  // clock
  input wire logic core_clk,
  // link pins
  output logic sclk,
  output logic cs_bar,
  output logic frame_sync,
  output logic serial_in,
  // readback
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic sdata;

  // idle levels; a pin the bench does not own must not look stable
  initial begin
    sclk = 1'b0;
    cs_bar = 1'b1;
    frame_sync = 1'b1;
    serial_in = 1'b0;
    sdata = 1'b0;
  end

  // data line toggles every cycle while the device is not selected
  always @(posedge core_clk) begin
    serial_in <= cs_bar ? ~serial_in : sdata;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // free serial clock periods; conversions count these too
  task automatic clocks(input int n);
    repeat (n) begin
      sclk <= 1'b1;
      idle(4);
      sclk <= 1'b0;
      idle(4);
    end
  endtask

  task automatic select();
    idle(1);
    cs_bar <= 1'b0;
    idle(6);
  endtask

  task automatic deselect();
    cs_bar <= 1'b1;
    frame_sync <= 1'b1;
    idle(6);
  endtask

  // one 16-bit frame; select stays low at the end so the caller can look at it
  task automatic xfer(input logic fs, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    frame_sync <= ~fs;
    idle(2);
    cs_bar <= 1'b0;
    idle(4);
    if (fs) begin
      frame_sync <= 1'b1;
      idle(4);
      frame_sync <= 1'b0;
      idle(4);
    end
    for (int i = 15; i >= 0; i--) begin
      if (!fs) sdata <= tx[i];
      idle(4);
      if (!fs) rx[i] = serial_out_oe ? serial_out : 1'bx;
      sclk <= 1'b1;
      if (fs) sdata <= tx[i];
      idle(4);
      if (fs) rx[i] = serial_out_oe ? serial_out : 1'bx;
      sclk <= 1'b0;
    end
    idle(6);
  endtask
endmodule // sap_host_model

//--- testbench/tb_serial_adc_host_port_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_serial_adc_host_port_control;
  import sap_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_start_bar = 1'b1;
  logic status_is_int = 1'b0;
  logic [1:0] conv_mode = 2'h0;
  logic long_sample = 1'b0;
  logic [11:0] adc_result = 12'h000;
  logic sclk, cs_bar, frame_sync, serial_in;
  logic serial_out, serial_out_oe, status_out, sample_track, cfg_strobe;
  logic [3:0] mux_select;
  logic [11:0] cfg_data;
  sap_pins_t pins;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int strobes = 0;
  logic [15:0] rx;
  logic [15:0] prev;
  logic [3:0] cmd;
  logic [11:0] word;
  logic fs;

  // bundle in the package's field order
  assign pins = {sclk, cs_bar, frame_sync, serial_in, sample_start_bar};

  sap_port i_sap_port (.core_clk(core_clk), .rst(rst), .pins(pins), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .status_out(status_out), .status_is_int(status_is_int),
    .conv_mode(conv_mode), .long_sample(long_sample), .adc_result(adc_result),
    .sample_track(sample_track), .mux_select(mux_select), .cfg_data(cfg_data), .cfg_strobe(cfg_strobe));

  sap_host_model i_sap_host_model (.core_clk(core_clk), .sclk(sclk), .cs_bar(cs_bar),
    .frame_sync(frame_sync), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // expected readback: result then the zero tail
  function automatic logic [15:0] expect_read(input logic [11:0] r);
    return {r, SAP_TAIL_ZEROS};
  endfunction

  // channels 0..7 then the three self tests
  function automatic logic [3:0] pick_cmd(input int r);
    return (r <= int'(SAP_CMD_LAST_CHAN)) ? 4'(r) : 4'(int'(SAP_CMD_TEST_FIRST) + r - 8);
  endfunction

  // status level 18 clocks after the command edge: low only when converting as eoc
  function automatic logic mid_status(input logic is_int, input logic lng, input logic [1:0] mode);
    return is_int | lng | (mode != SAP_MODE_EOC);
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // config strobes are one-cycle pulses, so count them as they pass
  always @(posedge core_clk) begin
    if (cfg_strobe === 1'b1) strobes++;
  end

  // hang guard, well above the ~12k cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(81));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    // extended sampling while deselected, interrupt lands mid-frame
    status_is_int <= 1'b1;
    adc_result <= 12'($urandom);
    sample_start_bar <= 1'b0;
    repeat (8) @(posedge core_clk);
    `CHK(sample_track, 1'b1)
    i_sap_host_model.clocks(20);
    `CHK(sample_track, 1'b1)
    sample_start_bar <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK({sample_track, status_out}, 2'b01)
    i_sap_host_model.clocks(20);
    i_sap_host_model.select();
    `CHK(serial_out_oe, 1'b1)
    i_sap_host_model.clocks(14);
    `CHK({status_out, serial_out_oe}, 2'b00)
    i_sap_host_model.deselect();
    i_sap_host_model.select();
    `CHK(status_out, 1'b1)
    i_sap_host_model.deselect();
    prev = expect_read(adc_result);
    $display("test extended_sampling done");
    // random frames in both framings with config writes between conversions
    for (int n = 0; n < 16; n++) begin
      cmd = pick_cmd($urandom_range(10));
      fs = 1'($urandom);
      word = 12'($urandom);
      status_is_int <= 1'($urandom);
      long_sample <= 1'($urandom);
      conv_mode <= 2'($urandom);
      adc_result <= 12'($urandom);
      i_sap_host_model.xfer(fs, {SAP_CMD_CFG_WRITE, word}, rx);
      i_sap_host_model.deselect();
      `CHK(cfg_data, word)
      `CHK(strobes, n + 1)
      i_sap_host_model.xfer(~fs, {cmd, 12'h000}, rx);
      `CHK(rx, prev)
      `CHK(mux_select, cmd)
      `CHK(serial_out_oe, 1'b0)
      i_sap_host_model.deselect();
      `CHK(serial_out_oe, 1'b0)
      i_sap_host_model.clocks(6);
      `CHK({sample_track, status_out}, {long_sample, mid_status(status_is_int, long_sample, conv_mode)})
      i_sap_host_model.clocks(46);
      `CHK({sample_track, status_out}, {1'b0, ~status_is_int})
      prev = expect_read(adc_result);
      i_sap_host_model.select();
      `CHK({serial_out_oe, status_out}, 2'b11)
      i_sap_host_model.deselect();
      $display("test random_frame %0d done", n);
    end
    complete_run();
  end
endmodule // tb_serial_adc_host_port_control
